// [verilog/apf_defines.svh]
`ifndef APF_DEFINES_SVH
`define APF_DEFINES_SVH

// word-address codes on the register port
`define APF_CODE_IMB_FIRST 5'h00
`define APF_CODE_IMB_LAST 5'h03
`define APF_CODE_OMB_FIRST 5'h04
`define APF_CODE_OMB_LAST 5'h07
`define APF_CODE_FIFO 5'h08
`define APF_CODE_BM_WADDR 5'h09
`define APF_CODE_BM_RADDR 5'h0C
`define APF_CODE_MB_STATUS 5'h0D
`define APF_CODE_INT_CTRL 5'h0E
`define APF_CODE_GEN_CTRL 5'h0F
`define APF_CODE_BM_WCOUNT 5'h16
`define APF_CODE_BM_RCOUNT 5'h17

// register storage
`define APF_RF_DEPTH 32
`define APF_RF_AW 5
`define APF_RF_RESET 32'h00000000

// fifo geometry: 32 bytes each
`define APF_FIFO_DEPTH 8
`define APF_FIFO_AW 3
`define APF_FIFO_CW 4
`define APF_FIFO_FULL 4'h8

// pin synchroniser vector and its idle value (all strobes inactive)
`define APF_SYNC_W 47
`define APF_SYNC_IDLE 47'h707B00000000

// lane masks
`define APF_LANES_ALL 4'hF
`define APF_LANES_LOW16 4'h3
`define APF_LANES_NONE 4'h0

`endif

// [verilog/apf_pkg.sv]
package apf_pkg;
   typedef logic [31:0] apf_word_t;
   typedef logic [15:0] apf_half_t;
   typedef logic [3:0] apf_lane_t;
   typedef logic [4:0] apf_code_t;
endpackage : apf_pkg

// [verilog/apf_regfile.sv]
`timescale 1ns/1ps
`include "apf_defines.svh"
module apf_regfile (
   input wire logic i_clock,
   input wire logic i_sys_rst,
   input wire logic i_we,
   input wire logic [`APF_RF_AW-1:0] i_waddr,
   input wire apf_pkg::apf_lane_t i_wmask,
   input wire apf_pkg::apf_word_t i_wdata,
   input wire logic [`APF_RF_AW-1:0] i_raddr,
   output apf_pkg::apf_word_t o_rdata
);
   apf_pkg::apf_word_t mem_q [`APF_RF_DEPTH];
   apf_pkg::apf_word_t rdata_q;

   genvar e, b;
   generate
      for (e = 0; e < `APF_RF_DEPTH; e++) begin : g_entry
         for (b = 0; b < 4; b++) begin : g_lane
            logic hit;
            assign hit = i_we && (i_waddr == (`APF_RF_AW)'(e)) && i_wmask[b];
            always_ff @(posedge i_clock) begin
               if (i_sys_rst) begin
                  mem_q[e][8*b +: 8] <= 8'(`APF_RF_RESET >> (8*b));
               end else if (hit) begin
                  mem_q[e][8*b +: 8] <= i_wdata[8*b +: 8];
               end
            end
         end
      end
   endgenerate

   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         rdata_q <= `APF_RF_RESET;
      end else begin
         rdata_q <= mem_q[i_raddr];
      end
   end

   assign o_rdata = rdata_q;
endmodule : apf_regfile

// [verilog/apf_fifo.sv]
`timescale 1ns/1ps
`include "apf_defines.svh"
module apf_fifo (
   input wire logic i_clock,
   input wire logic i_sys_rst,
   input wire logic i_wr_valid,
   output logic o_wr_ready,
   input wire apf_pkg::apf_word_t i_wr_data,
   output logic o_rd_valid,
   input wire logic i_rd_ready,
   output apf_pkg::apf_word_t o_rd_data,
   output logic [`APF_FIFO_CW-1:0] o_count
);
   apf_pkg::apf_word_t mem_q [`APF_FIFO_DEPTH];
   logic [`APF_FIFO_AW-1:0] wptr_q;
   logic [`APF_FIFO_AW-1:0] rptr_q;
   logic [`APF_FIFO_CW-1:0] count_q;
   logic push;
   logic pop;

   assign o_wr_ready = (count_q != `APF_FIFO_FULL);
   assign o_rd_valid = (count_q != '0);
   assign push = i_wr_valid && o_wr_ready;
   assign pop = i_rd_ready && o_rd_valid;
   assign o_rd_data = mem_q[rptr_q];
   assign o_count = count_q;

   always_ff @(posedge i_clock) begin
      if (push) begin
         mem_q[wptr_q] <= i_wr_data;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         wptr_q <= '0;
         rptr_q <= '0;
         count_q <= '0;
      end else begin
         wptr_q <= wptr_q + (`APF_FIFO_AW)'(push);
         rptr_q <= rptr_q + (`APF_FIFO_AW)'(pop);
         count_q <= count_q + (`APF_FIFO_CW)'(push) - (`APF_FIFO_CW)'(pop);
      end
   end
endmodule : apf_fifo

// [verilog/apf_port.sv]
`timescale 1ns/1ps
`include "apf_defines.svh"
// What this block does
// - codes 0-3 incoming mailboxes, 4-7 outgoing mailboxes, 8 the fifo port
// - codes 13, 14, 15 are mailbox status, interrupt control, general control
// - code 22 is write transfer count, code 23 read transfer count
// - 32-bit mode: top byte enable gates register writes and select read drive of bits 31:24
// - 32-bit mode: lower three enables gate register writes and select read drive of their own lanes
// - write strobe with select writes addressed register, enabled lanes only
// - read strobe with select drives addressed register, enabled lanes only
// - width select low means 32-bit accesses, high means 16-bit accesses
// - 16-bit mode: top enable pin selects upper or lower half-word of a register; fifo halves go low first, then high
// - 16-bit mode: only data lines 15:0 carry registers and fifo data
// - direct write strobe pushes outbound fifo without select or address
// - direct read strobe pops inbound fifo without select or address
// - direct fifo accesses follow the selected 32-bit or 16-bit width
// - outbound flag high when fifo full; low serves as write request
// - inbound flag high when fifo empty; low serves as read request
module apf_port (
   input wire logic i_clock,
   input wire logic i_sys_rst,
   input wire logic i_chip_select_n,
   input wire logic i_read_strobe_n,
   input wire logic i_write_strobe_n,
   input wire apf_pkg::apf_code_t i_word_addr,
   input wire logic i_top_byte_lane_enable_n,
   input wire logic [2:0] i_lower_byte_lane_enables_n,
   input wire logic i_width_select,
   input wire logic i_direct_fifo_write_strobe_n,
   input wire logic i_direct_fifo_read_strobe_n,
   input wire apf_pkg::apf_word_t i_data,
   output apf_pkg::apf_word_t o_data,
   output apf_pkg::apf_lane_t o_data_oe,
   output logic o_outbound_fifo_flag,
   output logic o_inbound_fifo_flag,
   output apf_pkg::apf_word_t o_pci_ob_data,
   output logic o_pci_ob_valid,
   input wire logic i_pci_ob_ready,
   input wire apf_pkg::apf_word_t i_pci_ib_data,
   input wire logic i_pci_ib_valid,
   output logic o_pci_ib_ready
);
   logic [`APF_SYNC_W-1:0] pins_raw;
   logic [`APF_SYNC_W-1:0] sync1_q;
   logic [`APF_SYNC_W-1:0] sync2_q;

   assign pins_raw = {i_chip_select_n, i_read_strobe_n, i_write_strobe_n, i_word_addr,
                      i_top_byte_lane_enable_n, i_lower_byte_lane_enables_n, i_width_select,
                      i_direct_fifo_write_strobe_n, i_direct_fifo_read_strobe_n, i_data};

   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         sync1_q <= `APF_SYNC_IDLE;
         sync2_q <= `APF_SYNC_IDLE;
      end else begin
         sync1_q <= pins_raw;
         sync2_q <= sync1_q;
      end
   end

   wire cs_n = sync2_q[46];
   wire rd_n = sync2_q[45];
   wire wr_n = sync2_q[44];
   wire [4:0] addr = sync2_q[43:39];
   wire top_n = sync2_q[38];
   wire [2:0] lo_n = sync2_q[37:35];
   wire wide16 = sync2_q[34];
   wire dfw_n = sync2_q[33];
   wire dfr_n = sync2_q[32];
   wire [31:0] din = sync2_q[31:0];

   wire cs = !cs_n;
   wire reg_wr = cs && !wr_n;
   wire reg_rd = cs && !rd_n;

   wire addr_mbox = (addr <= `APF_CODE_OMB_LAST);
   wire addr_fifo = (addr == `APF_CODE_FIFO);
   wire addr_ctrl = (addr >= `APF_CODE_MB_STATUS) && (addr <= `APF_CODE_GEN_CTRL);
   wire addr_count = (addr == `APF_CODE_BM_WCOUNT) || (addr == `APF_CODE_BM_RCOUNT);
   wire addr_bmaddr = (addr == `APF_CODE_BM_WADDR) || (addr == `APF_CODE_BM_RADDR);
   wire addr_mapped = addr_mbox || addr_ctrl || addr_count || addr_bmaddr;

   wire hsel = top_n;
   wire [3:0] lanes32 = ~{top_n, lo_n};
   wire [1:0] lanes_lo = ~lo_n[1:0];
   wire [3:0] lanes16 = hsel ? {lanes_lo, 2'b00} : {2'b00, lanes_lo};
   wire [3:0] wmask = wide16 ? lanes16 : lanes32;
   wire [31:0] wdata = wide16 ? {din[15:0], din[15:0]} : din;

   wire rf_we = reg_wr && addr_mapped;
   wire [3:0] rf_wmask = wmask;
   wire [4:0] rf_waddr = addr;
   apf_pkg::apf_word_t rf_rdata;

   apf_regfile u_regs (
      .i_clock(i_clock),
      .i_sys_rst(i_sys_rst),
      .i_we(rf_we),
      .i_waddr(rf_waddr),
      .i_wmask(rf_wmask),
      .i_wdata(wdata),
      .i_raddr(addr),
      .o_rdata(rf_rdata)
   );

   wire fifo_wr_acc = !dfw_n || (reg_wr && addr_fifo);
   wire fifo_rd_acc = !dfr_n || (reg_rd && addr_fifo);
   wire rd_any = reg_rd || fifo_rd_acc;

   logic half_wr_q;
   logic half_rd_q;
   apf_pkg::apf_half_t low_hold_q;
   logic ob_full;
   logic ob_ready;
   logic ib_valid;
   logic ib_empty;
   logic [`APF_FIFO_CW-1:0] ob_count;
   logic [`APF_FIFO_CW-1:0] ib_count;
   apf_pkg::apf_word_t ib_head;

   // 16-bit fifo halves pair low first, then high
   wire ob_push = fifo_wr_acc && (!wide16 || half_wr_q);
   wire [31:0] ob_wdata = wide16 ? {din[15:0], low_hold_q} : din;
   wire ib_pop = fifo_rd_acc && (!wide16 || half_rd_q);
   wire ob_pop = o_pci_ob_valid && i_pci_ob_ready;
   wire ib_fill = i_pci_ib_valid && o_pci_ib_ready;
   assign ob_full = !ob_ready;
   assign ib_empty = !ib_valid;

   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         half_wr_q <= 1'b0;
         half_rd_q <= 1'b0;
         low_hold_q <= 16'h0000;
      end else begin
         half_wr_q <= wide16 ? (half_wr_q ^ fifo_wr_acc) : 1'b0;
         half_rd_q <= wide16 ? (half_rd_q ^ fifo_rd_acc) : 1'b0;
         if (fifo_wr_acc && !half_wr_q) begin
            low_hold_q <= din[15:0];
         end
      end
   end

   // a push into a full fifo is dropped; the flag warns the writer
   apf_fifo u_outbound (
      .i_clock(i_clock),
      .i_sys_rst(i_sys_rst),
      .i_wr_valid(ob_push),
      .o_wr_ready(ob_ready),
      .i_wr_data(ob_wdata),
      .o_rd_valid(o_pci_ob_valid),
      .i_rd_ready(i_pci_ob_ready),
      .o_rd_data(o_pci_ob_data),
      .o_count(ob_count)
   );

   apf_fifo u_inbound (
      .i_clock(i_clock),
      .i_sys_rst(i_sys_rst),
      .i_wr_valid(i_pci_ib_valid),
      .o_wr_ready(o_pci_ib_ready),
      .i_wr_data(i_pci_ib_data),
      .o_rd_valid(ib_valid),
      .i_rd_ready(ib_pop),
      .o_rd_data(ib_head),
      .o_count(ib_count)
   );

   // read stage one: capture control beside the registered register data
   wire [3:0] rd_lanes_sel = wide16 ? {2'b00, lanes_lo} : lanes32;
   wire [3:0] rd_lanes_dir = wide16 ? `APF_LANES_LOW16 : `APF_LANES_ALL;
   wire [3:0] rd_oe_d = !dfr_n ? rd_lanes_dir : rd_lanes_sel;
   wire rd_upper_d = wide16 && (fifo_rd_acc ? half_rd_q : hsel);

   logic rd_valid_q;
   logic rd_fifo_q;
   logic rd_mapped_q;
   logic rd_upper_q;
   logic rd_wide16_q;
   logic [3:0] rd_oe_q;
   apf_pkg::apf_word_t fifo_word_q;
   apf_pkg::apf_word_t data_q;
   apf_pkg::apf_lane_t oe_q;
   logic ob_flag_q;
   logic ib_flag_q;

   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         rd_valid_q <= 1'b0;
         rd_fifo_q <= 1'b0;
         rd_mapped_q <= 1'b0;
         rd_upper_q <= 1'b0;
         rd_wide16_q <= 1'b0;
         rd_oe_q <= `APF_LANES_NONE;
         fifo_word_q <= 32'h00000000;
      end else begin
         rd_valid_q <= rd_any;
         rd_fifo_q <= fifo_rd_acc;
         rd_mapped_q <= addr_mapped;
         rd_upper_q <= rd_upper_d;
         rd_wide16_q <= wide16;
         rd_oe_q <= rd_oe_d;
         fifo_word_q <= ib_head;
      end
   end

   // addressed data selected for the bus
   wire [31:0] rd_src = rd_fifo_q ? fifo_word_q : (rd_mapped_q ? rf_rdata : 32'h00000000);
   // 16-bit reads land on the low lines only
   wire [15:0] rd_half = rd_upper_q ? rd_src[31:16] : rd_src[15:0];
   wire [31:0] rd_out = rd_wide16_q ? {16'h0000, rd_half} : rd_src;
   // undriven lanes read as zero, so a masked byte never leaks
   wire [31:0] rd_lane_mask = {{8{rd_oe_q[3]}}, {8{rd_oe_q[2]}}, {8{rd_oe_q[1]}}, {8{rd_oe_q[0]}}};

   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         data_q <= 32'h00000000;
         oe_q <= `APF_LANES_NONE;
      end else begin
         data_q <= rd_valid_q ? (rd_out & rd_lane_mask) : 32'h00000000;
         oe_q <= rd_valid_q ? rd_oe_q : `APF_LANES_NONE;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         ob_flag_q <= 1'b0;
         ib_flag_q <= 1'b1;
      end else begin
         ob_flag_q <= ob_full;
         ib_flag_q <= ib_empty;
      end
   end

   assign o_data = data_q;
   assign o_data_oe = oe_q;
   assign o_outbound_fifo_flag = ob_flag_q;
   assign o_inbound_fifo_flag = ib_flag_q;

   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (i_sys_rst);

   mbox_decode_a: assert property ((reg_wr && addr == `APF_CODE_OMB_LAST) |-> (rf_we && rf_waddr == 5'h07))
      else $error("outgoing mailbox write not decoded");
   ctrl_decode_a: assert property ((reg_wr && addr == `APF_CODE_GEN_CTRL) |-> (rf_we && rf_waddr == 5'h0F))
      else $error("general control write not decoded");
   count_decode_a: assert property ((reg_wr && addr == `APF_CODE_BM_RCOUNT) |->
      (rf_we && rf_waddr == 5'h17))
      else $error("read count write not decoded");
   top_lane_a: assert property ((reg_rd && !wide16 && top_n && dfr_n) |-> ##2 !o_data_oe[3])
      else $error("top lane driven while disabled");
   read_lanes_a: assert property ((reg_rd && !wide16 && dfr_n) |-> ##2
      (o_data_oe == $past(lanes32, 2)))
      else $error("read lane drive mismatch");
   no_select_a: assert property ((cs_n && dfw_n && dfr_n) |-> ##2 (o_data_oe == 4'h0))
      else $error("bus driven without select");
   write_mask_a: assert property ((reg_wr && !wide16 && addr_mapped) |-> (rf_wmask == ~{top_n, lo_n}))
      else $error("write lanes differ from enables");
   idle_release_a: assert property ((!rd_any ##1 !rd_any) |=> (o_data_oe == 4'h0))
      else $error("bus driven with no read");
   direct_wide_a: assert property ((!dfr_n && !wide16) |-> ##2 (o_data_oe == 4'hF))
      else $error("direct 32-bit read not on all lanes");
   half_select_a: assert property ((rf_we && wide16 && hsel) |-> (rf_wmask[1:0] == 2'b00))
      else $error("upper half write touched low lanes");
   narrow_lines_a: assert property ((rd_any && wide16) |-> ##2
      (o_data_oe[3:2] == 2'b00 && o_data[31:16] == 16'h0000))
      else $error("16-bit read drove high lines");
   direct_push_a: assert property ((!dfw_n && !wide16 && !ob_full && !ob_pop) |=>
      (ob_count == $past(ob_count) + 1))
      else $error("direct write did not push");
   direct_pop_a: assert property ((!dfr_n && !wide16 && !ib_empty && !ib_fill) |=>
      (ib_count == $past(ib_count) - 1))
      else $error("direct read did not pop");
   half_pair_a: assert property ((!dfw_n && wide16 && !half_wr_q && !ob_pop) |=>
      (ob_count == $past(ob_count)))
      else $error("first half pushed early");
   out_flag_a: assert property (1'b1 |=> (o_outbound_fifo_flag == $past(ob_count == 4'h8)))
      else $error("outbound flag wrong");
   in_flag_a: assert property (1'b1 |=> (o_inbound_fifo_flag == $past(ib_count == 4'h0)))
      else $error("inbound flag wrong");
   strobe_sample_a: assert property (rd_any |-> ##2 (o_data_oe == $past(rd_oe_d, 2)))
      else $error("sampled read not driven once");

   reg_read_c: cover property (reg_wr ##1 reg_rd ##2 (o_data_oe != 4'h0));
   half_pair_c: cover property ((!dfw_n && wide16) ##2 (!dfw_n && wide16));
   ob_full_c: cover property (o_outbound_fifo_flag);
   ib_read_c: cover property (!dfr_n && !ib_empty);
endmodule : apf_port

// [sim/apf_pci_model.sv]
`timescale 1ns/1ps
module apf_pci_model (
   input wire logic i_clock,
   input wire logic i_sys_rst,
   input wire logic i_stall,
   input wire apf_pkg::apf_word_t i_ob_data,
   input wire logic i_ob_valid,
   output logic o_ob_ready,
   output apf_pkg::apf_word_t o_ib_data,
   output logic o_ib_valid,
   input wire logic i_ib_ready
);
   apf_pkg::apf_word_t got[$];
   apf_pkg::apf_word_t feed[$];
   always @(posedge i_clock) begin
      if (i_sys_rst) begin
         o_ob_ready <= 1'b0;
         o_ib_valid <= 1'b0;
         o_ib_data <= 32'h00000000;
      end else begin
         if (i_ob_valid === 1'b1 && o_ob_ready) begin
            got.push_back(i_ob_data);
         end
         if (o_ib_valid && i_ib_ready === 1'b1) begin
            void'(feed.pop_front());
         end
         o_ob_ready <= !i_stall;
         o_ib_valid <= feed.size() > 0;
         // idle data keeps toggling so a stale word never passes for a fresh one
         o_ib_data <= (feed.size() > 0) ? feed[0] : ~o_ib_data;
      end
   end
endmodule : apf_pci_model

// [sim/apf_tb.sv]
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin check_count++; if ((gt) !== (ex)) begin mismatches++; \
   $display("ERROR %s expected %h seen %h", nm, ex, gt); end end
module tb;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic cs_n = 1'b1;
   logic rd_n = 1'b1;
   logic wr_n = 1'b1;
   apf_pkg::apf_code_t addr = 5'h00;
   logic top_n = 1'b1;
   logic [2:0] low_n = 3'h7;
   logic w16 = 1'b0;
   logic dfw_n = 1'b1;
   logic dfr_n = 1'b1;
   logic stall = 1'b0;
   apf_pkg::apf_word_t din = 32'hFFFFFFFF;
   apf_pkg::apf_word_t o_data, ob_data, ib_data;
   apf_pkg::apf_lane_t o_data_oe;
   logic ob_flag, ib_flag, ob_valid, ob_ready, ib_valid, ib_ready;
   int mismatches = 0;
   int check_count = 0;
   always #50 clk = ~clk;
   apf_port i_dut (.i_clock(clk), .i_sys_rst(rst), .i_chip_select_n(cs_n), .i_read_strobe_n(rd_n),
      .i_write_strobe_n(wr_n), .i_word_addr(addr), .i_top_byte_lane_enable_n(top_n),
      .i_lower_byte_lane_enables_n(low_n), .i_width_select(w16), .i_direct_fifo_write_strobe_n(dfw_n),
      .i_direct_fifo_read_strobe_n(dfr_n), .i_data(din), .o_data(o_data), .o_data_oe(o_data_oe),
      .o_outbound_fifo_flag(ob_flag), .o_inbound_fifo_flag(ib_flag), .o_pci_ob_data(ob_data),
      .o_pci_ob_valid(ob_valid), .i_pci_ob_ready(ob_ready), .i_pci_ib_data(ib_data),
      .i_pci_ib_valid(ib_valid), .o_pci_ib_ready(ib_ready));
   apf_pci_model i_pci (.i_clock(clk), .i_sys_rst(rst), .i_stall(stall), .i_ob_data(ob_data),
      .i_ob_valid(ob_valid), .o_ob_ready(ob_ready), .o_ib_data(ib_data), .o_ib_valid(ib_valid),
      .i_ib_ready(ib_ready));
   task automatic pins(input logic c, r, w, input logic [4:0] a, input logic [3:0] b, input logic m,
      input logic [31:0] d, input logic fw, fr);
      @(posedge clk);
      cs_n <= c;
      rd_n <= r;
      wr_n <= w;
      addr <= a;
      top_n <= b[3];
      low_n <= b[2:0];
      w16 <= m;
      din <= d;
      dfw_n <= fw;
      dfr_n <= fr;
      @(posedge clk);
      cs_n <= 1'b1;
      rd_n <= 1'b1;
      wr_n <= 1'b1;
      dfw_n <= 1'b1;
      dfr_n <= 1'b1;
      din <= 32'hFFFFFFFF;
   endtask : pins
   task automatic wreg(input logic c, input logic [4:0] a, input logic [3:0] b, input logic m,
      input logic [31:0] d);
      pins(c, 1'b1, 1'b0, a, b, m, d, 1'b1, 1'b1);
      repeat (3) @(posedge clk);
   endtask : wreg
   task automatic rreg(input logic c, r, fr, input logic [4:0] a, input logic [3:0] b, input logic m,
      output apf_pkg::apf_word_t q, output apf_pkg::apf_lane_t e);
      pins(c, r, 1'b1, a, b, m, 32'hFFFFFFFF, 1'b1, fr);
      q = 32'h00000000;
      e = 4'h0;
      repeat (6) begin
         @(negedge clk);
         if (o_data_oe !== 4'h0 && e === 4'h0) begin
            q = o_data;
            e = o_data_oe;
         end
      end
   endtask : rreg
   task automatic t_map;
      apf_pkg::apf_code_t codes [14] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07,
         5'h09, 5'h0C, 5'h0D, 5'h0E, 5'h0F, 5'h16};
      apf_pkg::apf_word_t q;
      apf_pkg::apf_lane_t e;
      for (int i = 0; i < 14; i++) wreg(1'b0, codes[i], 4'h0, 1'b0, {8'hA5, 3'h0, codes[i], 11'h000, codes[i]});
      wreg(1'b0, 5'h17, 4'h0, 1'b0, 32'h5A000017);
      wreg(1'b0, 5'h0A, 4'h0, 1'b0, 32'h12345678);
      for (int i = 0; i < 14; i++) begin
         rreg(1'b0, 1'b0, 1'b1, codes[i], 4'h0, 1'b0, q, e);
         `CHK("map data", {8'hA5, 3'h0, codes[i], 11'h000, codes[i]}, q)
      end
      rreg(1'b0, 1'b0, 1'b1, 5'h17, 4'h0, 1'b0, q, e);
      `CHK("read count", 32'h5A000017, q)
      rreg(1'b0, 1'b0, 1'b1, 5'h0A, 4'h0, 1'b0, q, e);
      `CHK("unmapped", 32'h00000000, q)
      $display("test map done");
   endtask : t_map
   task automatic t_lanes;
      apf_pkg::apf_word_t q;
      apf_pkg::apf_lane_t e;
      wreg(1'b0, 5'h00, 4'h0, 1'b0, 32'h11223344);
      wreg(1'b0, 5'h00, 4'h6, 1'b0, 32'hAABBCCDD);
      rreg(1'b0, 1'b0, 1'b1, 5'h00, 4'h8, 1'b0, q, e);
      `CHK("low lanes oe", 4'h7, e)
      `CHK("low lanes", 32'h002233DD, q)
      rreg(1'b0, 1'b0, 1'b1, 5'h00, 4'h7, 1'b0, q, e);
      `CHK("top lane oe", 4'h8, e)
      `CHK("top lane", 32'hAA000000, q)
      $display("test lanes done");
   endtask : t_lanes
   task automatic t_nosel;
      apf_pkg::apf_word_t q;
      apf_pkg::apf_lane_t e;
      wreg(1'b1, 5'h01, 4'h0, 1'b0, 32'hDEADDEAD);
      rreg(1'b1, 1'b0, 1'b1, 5'h01, 4'h0, 1'b0, q, e);
      `CHK("no select oe", 4'h0, e)
      rreg(1'b0, 1'b0, 1'b1, 5'h01, 4'h0, 1'b0, q, e);
      `CHK("no select write", 32'hA5010001, q)
      $display("test select done");
   endtask : t_nosel
   task automatic t_half;
      apf_pkg::apf_word_t q;
      apf_pkg::apf_lane_t e;
      wreg(1'b0, 5'h02, 4'h4, 1'b1, 32'hFFFF1234);
      wreg(1'b0, 5'h02, 4'hC, 1'b1, 32'h0000BEEF);
      rreg(1'b0, 1'b0, 1'b1, 5'h02, 4'hC, 1'b1, q, e);
      `CHK("half oe", 4'h3, e)
      `CHK("upper half", 16'hBEEF, q[15:0])
      rreg(1'b0, 1'b0, 1'b1, 5'h02, 4'h0, 1'b0, q, e);
      `CHK("halves joined", 32'hBEEF1234, q)
      $display("test half done");
   endtask : t_half
   task automatic t_outbound;
      stall <= 1'b1;
      `CHK("ob request", 1'b0, ob_flag)
      for (int k = 0; k < 9; k++) pins(1'b1, 1'b1, 1'b1, 5'h1F, 4'hF, 1'b0, 32'h0B000000 + k, 1'b0, 1'b1);
      repeat (4) @(negedge clk);
      `CHK("ob full", 1'b1, ob_flag)
      stall <= 1'b0;
      repeat (20) @(negedge clk);
      `CHK("ob drained", 8, i_pci.got.size())
      for (int k = 0; k < 8; k++) `CHK("ob word", 32'h0B000000 + k, i_pci.got[k])
      `CHK("ob empty", 1'b0, ob_flag)
      pins(1'b1, 1'b1, 1'b1, 5'h00, 4'hF, 1'b1, 32'hFFFF5678, 1'b0, 1'b1);
      pins(1'b1, 1'b1, 1'b1, 5'h00, 4'hF, 1'b1, 32'hFFFF1234, 1'b0, 1'b1);
      repeat (8) @(negedge clk);
      `CHK("ob half word", 32'h12345678, i_pci.got[8])
      wreg(1'b0, 5'h08, 4'h0, 1'b0, 32'h0B0B0808);
      repeat (4) @(negedge clk);
      `CHK("ob port word", 32'h0B0B0808, i_pci.got[9])
      $display("test outbound done");
   endtask : t_outbound
   task automatic t_inbound;
      apf_pkg::apf_word_t q;
      apf_pkg::apf_lane_t e;
      `CHK("ib empty", 1'b1, ib_flag)
      i_pci.feed.push_back(32'hCAFE0001);
      i_pci.feed.push_back(32'hCAFE0002);
      repeat (6) @(negedge clk);
      `CHK("ib request", 1'b0, ib_flag)
      rreg(1'b1, 1'b1, 1'b0, 5'h1F, 4'hF, 1'b0, q, e);
      `CHK("ib word", 32'hCAFE0001, q)
      `CHK("ib oe", 4'hF, e)
      rreg(1'b1, 1'b1, 1'b0, 5'h1F, 4'hF, 1'b1, q, e);
      `CHK("ib low half", 16'h0002, q[15:0])
      `CHK("ib half oe", 4'h3, e)
      rreg(1'b1, 1'b1, 1'b0, 5'h1F, 4'hF, 1'b1, q, e);
      `CHK("ib high half", 16'hCAFE, q[15:0])
      i_pci.feed.push_back(32'hCAFE0003);
      repeat (6) @(negedge clk);
      rreg(1'b0, 1'b0, 1'b1, 5'h08, 4'h0, 1'b0, q, e);
      `CHK("ib port word", 32'hCAFE0003, q)
      repeat (4) @(negedge clk);
      `CHK("ib drained", 1'b1, ib_flag)
      $display("test inbound done");
   endtask : t_inbound
   task automatic results;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : results
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      t_map();
      t_lanes();
      t_nosel();
      t_half();
      t_outbound();
      t_inbound();
      results();
   end
   initial begin
      repeat (3000) @(posedge clk);
      mismatches++;
      results();
   end
endmodule : tb
